/* File: bench/cal_ctrl_model.sv */
// Behavioural system controller driving the calibration trigger pin
`timescale 1ns/1ps
module cal_ctrl_model (
  input  wire logic clock_in,
  input  wire logic rst_in,
  input  wire logic trig_cmd_in,
  input  wire logic cal_status_pin_in,
  output logic      cal_trigger_pin_out,
  output logic      status_seen_out
);
  // Pin idles high so the spare stays asleep until a cycle is wanted
  initial
  begin
    cal_trigger_pin_out = 1'b1;
    status_seen_out     = 1'b0;
  end

  // Pin moves just after an edge and holds until commanded again
  always @(posedge clock_in)
  begin
    cal_trigger_pin_out <= #2 trig_cmd_in;
  end

  // Sticky record that the finished indication was seen; reset clears it so each scenario starts fresh
  always @(posedge clock_in)
  begin
    if (rst_in)
      status_seen_out <= 1'b0;
    else if (cal_status_pin_in === 1'b1)
    begin
      status_seen_out <= 1'b1;
    end
  end
endmodule

/* File: bench/low_power_background_cal_sequencer_tb.sv */
// Self-checking bench for the low-power background calibration sequencer
`timescale 1ns/1ps
module low_power_background_cal_sequencer_tb;
  // Short counts keep the run brief; the sleep, wake and calibration length checks derive from these
  localparam int CAL = 4;
  // Foreground pass needs at least one cycle per core, or the last cores go unwritten
  localparam int FG  = 8;
  localparam int STP = 2;
  localparam int SLP = 3;
  localparam int WK  = 2;
  typedef struct packed {
    logic [2:0]  idx;
    logic [11:0] wr;
  } row_t;
  logic               clock_in;
  logic               rst_in;
  logic               sw_trig;
  logic               trig_cmd;
  logic               pin;
  logic               seen;
  logic               fg_start;
  logic               trim_wr;
  logic               status_pin;
  logic               foreground_done_flag;
  logic               os_act;
  logic [2:0]         trim_idx;
  logic [2:0]         rd_idx;
  logic [11:0]        trim_data;
  logic [11:0]        adc_data;
  logic [11:0]        data_out;
  logic [11:0]        trim_out;
  low_power_background_mode_pkg::cal_cfg_t  cfg;
  low_power_background_mode_pkg::cal_stat_t stat;
  wire logic [3:0]    obs;
  int                 n_fail;
  int                 checks_done;
  int                 cycles;
  int                 n;
  row_t               rows [6];

  assign obs = {foreground_done_flag, stat.cal_done, stat.cal_busy, stat.spare_pwr};

  low_power_background_mode_sequencer #(.CAL_CYCLES(CAL), .FG_CAL_CYCLES(FG), .STEP_CYCLES(STP)) u_low_power_background_mode_sequencer (
    .clock_in                 (clock_in),
    .rst_in                   (rst_in),
    .cfg_in                   (cfg),
    .software_cal_trigger_in  (sw_trig),
    .cal_trigger_pin_in       (pin),
    .fg_start_in              (fg_start),
    .trim_wr_in               (trim_wr),
    .trim_idx_in              (trim_idx),
    .trim_data_in             (trim_data),
    .trim_rd_idx_in           (rd_idx),
    .adc_data_in              (adc_data),
    .stat_out                 (stat),
    .cal_status_pin_out       (status_pin),
    .foreground_done_flag_out (foreground_done_flag),
    .os_cal_active_out        (os_act),
    .data_out                 (data_out),
    .core_offset_trim_out     (trim_out)
  );

  cal_ctrl_model u_cal_ctrl_model (
    .clock_in            (clock_in),
    .rst_in              (rst_in),
    .trig_cmd_in         (trig_cmd),
    .cal_status_pin_in   (status_pin),
    .cal_trigger_pin_out (pin),
    .status_seen_out     (seen)
  );

  // ----------------------------------------
  // Clock, watchdog and reporting
  // ----------------------------------------
  initial
  begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end

  // Ceiling is several times the expected run so a hung wait still ends
  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_fail++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check_bit(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic check_val(input string what, input logic [11:0] exp, input logic [11:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_cnt(input string what, input int k, input int lo, input int hi);
    checks_done++;
    if (k < lo || k > hi)
    begin
      n_fail++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, k);
    end
  endtask

  // Counts settled edges until an observed flag takes a value, bounded
  task automatic wait_for(input int f, input logic v, input int lim, output int k);
    k = 0;
    while (obs[f] !== v && k < lim)
    begin
      @(posedge clock_in);
      #1;
      k++;
    end
  endtask

  task automatic do_reset();
    @(posedge clock_in);
    rst_in <= 1'b1;
    repeat (6) @(posedge clock_in);
    rst_in <= 1'b0;
    #1;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    rst_in = 1'b1;
    cfg = '0;
    cfg.variant = 2'h2;
    cfg.sleep_dly = 8'h03;
    cfg.wake_dly = 8'h02;
    sw_trig = 1'b1;
    trig_cmd = 1'b1;
    fg_start = 1'b0;
    trim_wr = 1'b0;
    trim_idx = 3'h0;
    trim_data = 12'h000;
    rd_idx = 3'h0;
    adc_data = 12'h000;
    rows = '{'{3'h0, 12'h123}, '{3'h1, 12'hFED}, '{3'h2, 12'h800},
             '{3'h3, 12'h7FF}, '{3'h4, 12'h001}, '{3'h5, 12'hA5A}};
    do_reset();
    check_bit("spare_pwr", 1'b0, stat.spare_pwr);
    check_bit("status_pin", 1'b0, status_pin);
    check_bit("foreground_done_flag", 1'b0, foreground_done_flag);
    check_val("data_out", 12'h000, data_out);
    // Each core keeps its own offset trim: write all, then read all
    foreach (rows[i])
    begin
      @(posedge clock_in);
      trim_wr <= 1'b1;
      trim_idx <= rows[i].idx;
      trim_data <= rows[i].wr;
    end
    @(posedge clock_in);
    trim_wr <= 1'b0;
    foreach (rows[i])
    begin
      @(posedge clock_in);
      rd_idx <= rows[i].idx;
      repeat (2) @(posedge clock_in);
      #1;
      check_val("trim", rows[i].wr, trim_out);
    end
    // Low-power enable alone must not run the spare sequence
    @(posedge clock_in);
    cfg.lowpwr_bg_enable <= 1'b1;
    wait_for(0, 1'b1, 40, n);
    check_cnt("idle_spare", n, 40, 40);
    // Automatic mode walk: sleep, wake, calibrate, swap, sleep again
    @(posedge clock_in);
    cfg.bg_cal_en <= 1'b1;
    wait_for(0, 1'b1, 60, n);
    check_cnt("sleep_len", n, SLP * STP, SLP * STP + 4);
    wait_for(1, 1'b1, 60, n);
    check_cnt("wake_len", n, WK * STP, WK * STP + 4);
    wait_for(0, 1'b0, 60, n);
    check_cnt("cal_len", n, CAL, CAL + 4);
    check_val("swapped", 12'h000, {9'h000, stat.swapped_core});
    check_val("spare_old", 12'h002, {9'h000, stat.spare_core});
    // Quad rotation hands the next calibration to the other spare
    @(posedge clock_in);
    #1;
    check_val("spare_id", 12'h003, {9'h000, stat.spare_core});
    wait_for(0, 1'b1, 60, n);
    check_cnt("resleep", n, SLP * STP, SLP * STP + 4);
    // Trigger mode from the pin, status pin showing the finished state
    @(posedge clock_in);
    cfg.trig_mode <= 1'b1;
    cfg.trig_src_pin <= 1'b1;
    cfg.status_sel <= 1'b1;
    do_reset();
    wait_for(0, 1'b1, 30, n);
    check_cnt("held_asleep", n, 30, 30);
    check_bit("status_idle", 1'b0, seen);
    @(posedge clock_in);
    trig_cmd <= 1'b0;
    wait_for(0, 1'b1, 12, n);
    check_cnt("pin_wake", n, 1, 8);
    wait_for(1, 1'b1, 30, n);
    check_cnt("trig_wake_len", n, WK * STP, WK * STP + 4);
    wait_for(2, 1'b1, 30, n);
    check_cnt("cal_done", n, CAL - 2, CAL + 4);
    repeat (12) @(posedge clock_in);
    #1;
    check_bit("held_pwr", 1'b1, stat.spare_pwr);
    check_val("no_swap", 12'h002, {9'h000, stat.spare_core});
    check_bit("status_pin", 1'b1, status_pin);
    check_bit("status_seen", 1'b1, seen);
    @(posedge clock_in);
    trig_cmd <= 1'b1;
    wait_for(0, 1'b0, 12, n);
    check_cnt("swap_on_rise", n, 1, 8);
    @(posedge clock_in);
    #1;
    check_val("swapped2", 12'h003, {9'h000, stat.spare_core});
    // Software bit as trigger source; pin stays high and is ignored
    @(posedge clock_in);
    cfg.trig_src_pin <= 1'b0;
    wait_for(0, 1'b1, 20, n);
    check_cnt("sw_asleep", n, 20, 20);
    @(posedge clock_in);
    sw_trig <= 1'b0;
    wait_for(0, 1'b1, 12, n);
    check_cnt("sw_wake", n, 1, 6);
    @(posedge clock_in);
    sw_trig <= 1'b1;
    // Foreground pass with one-time offset: offset enable before cal enable
    cfg <= '0;
    adc_data <= 12'h5A5;
    do_reset();
    @(posedge clock_in);
    cfg.variant <= 2'h2;
    cfg.fg_os_en <= 1'b1;
    @(posedge clock_in);
    cfg.bg_cal_en <= 1'b1;
    @(posedge clock_in);
    fg_start <= 1'b1;
    @(posedge clock_in);
    fg_start <= 1'b0;
    repeat (2) @(posedge clock_in);
    #1;
    check_val("mid_code", 12'h000, data_out);
    check_bit("os_active", 1'b1, os_act);
    wait_for(3, 1'b1, 6 * FG + 40, n);
    check_bit("foreground_done_flag", 1'b1, foreground_done_flag);
    // Trims are read only once the done flag is up
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clock_in);
      rd_idx <= i[2:0];
      repeat (2) @(posedge clock_in);
      #1;
      check_val("os_trim", 12'hA5B, trim_out);
    end
    // Background offset owns the trims, so a user write must not land
    @(posedge clock_in);
    cfg.bg_os_en <= 1'b1;
    @(posedge clock_in);
    trim_wr <= 1'b1;
    trim_idx <= 3'h0;
    trim_data <= 12'h111;
    @(posedge clock_in);
    trim_wr <= 1'b0;
    rd_idx <= 3'h0;
    repeat (2) @(posedge clock_in);
    #1;
    check_bit("os_owned", 1'b1, os_act);
    check_val("trim_kept", 12'hA5B, trim_out);
    print_verdict();
  end
endmodule

/* File: inc/low_power_background_mode_pkg.sv */
// Package of constants and carrier types for the low-power background calibration sequencer
// Contract
// - With low-power enable set, spare cores stay powered down until due for calibration.
// - Trigger-mode 0 selects timed automatic calibration; 1 selects trigger-controlled operation.
// - Automatic mode: spare sleeps for the sleep-delay setting before waking.
// - After waking, wait the wake-delay setting before calibration starts.
// - Automatic mode: swap immediately when calibration ends, then sleep the released core.
// - Trigger mode: software bit or external pin is the trigger; it alone starts cycles.
// - Trigger mode: spare held asleep while the trigger is high.
// - Trigger mode: low trigger wakes the spare; calibration after the wake delay.
// - Trigger mode: swap needs calibration done and trigger high; else spare waits powered.
// - Status-select 1 drives the status pin with the calibration-finished indication.
// - Foreground offset enable calibrates buffer offset once during foreground calibration.
// - Background offset enable keeps correcting offset during background calibration.
// - Foreground offset plus background enable calibrates all six cores in foreground pass.
// - Spare-reference option calibrates main cores to match the spare core offset.
// - A separate offset trim is kept for each core zero through five.
// - Gain trims are never changed by any calibration.
// - Full-scale setting applies to all inputs together; gain trims match per input.
// - Trims of absent inputs on smaller variants have no effect.
// - Two-channel variant: cores 0 and 1 share spare core 2.
// - During foreground calibration the output code is mid-scale zero.
package low_power_background_mode_pkg;
  localparam int NUM_CORES      = 6;
  localparam int TRIM_W         = 12;
  localparam int GAIN_W         = 12;
  localparam int DATA_W         = 12;
  localparam int DLY_W          = 8;
  // One delay step is this many nanoseconds; the settings count steps
  localparam int DLY_STEP_NS    = 1000;
  localparam int CLK_PERIOD_NS  = 50;
  localparam int DLY_STEP_CYC   = (DLY_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAL_CYC        = 64;
  localparam int FG_CAL_CYC     = 64;
  localparam logic [DATA_W-1:0] MID_CODE = 12'h000;
  localparam logic [2:0] CORE_SPARE_LO = 3'h2;
  localparam logic [2:0] CORE_SPARE_HI = 3'h3;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SLEEP = 3'b001,
    ST_WAKE  = 3'b011,
    ST_CAL   = 3'b010,
    ST_HOLD  = 3'b110,
    ST_SWAP  = 3'b111
  } lp_state_t;

  typedef struct packed {
    logic             bg_cal_en;
    logic             lowpwr_bg_enable;
    logic             trig_mode;
    logic             trig_src_pin;
    logic             status_sel;
    logic             fg_os_en;
    logic             bg_os_en;
    logic             spare_ref;
    logic [1:0]       variant;
    logic [DLY_W-1:0] sleep_dly;
    logic [DLY_W-1:0] wake_dly;
  } cal_cfg_t;

  typedef struct packed {
    logic       spare_pwr;
    logic       cal_busy;
    logic       cal_done;
    logic [2:0] spare_core;
    logic [2:0] swapped_core;
  } cal_stat_t;
endpackage

/* File: src/low_power_background_mode_sequencer.sv */
// Low-power background calibration sequencer top level
`timescale 1ns/1ps
module low_power_background_mode_sequencer #(
  parameter int CAL_CYCLES    = low_power_background_mode_pkg::CAL_CYC,
  parameter int FG_CAL_CYCLES = low_power_background_mode_pkg::FG_CAL_CYC,
  parameter int STEP_CYCLES   = low_power_background_mode_pkg::DLY_STEP_CYC
) (
  input  wire logic                            clock_in,
  input  wire logic                            rst_in,
  input  wire low_power_background_mode_pkg::cal_cfg_t              cfg_in,
  input  wire logic                            software_cal_trigger_in,
  input  wire logic                            cal_trigger_pin_in,
  input  wire logic                            fg_start_in,
  input  wire logic                            trim_wr_in,
  input  wire logic [2:0]                      trim_idx_in,
  input  wire logic [low_power_background_mode_pkg::TRIM_W-1:0]     trim_data_in,
  input  wire logic [2:0]                      trim_rd_idx_in,
  input  wire logic [low_power_background_mode_pkg::DATA_W-1:0]     adc_data_in,
  output low_power_background_mode_pkg::cal_stat_t                  stat_out,
  output logic                                 cal_status_pin_out,
  output logic                                 foreground_done_flag_out,
  output logic                                 os_cal_active_out,
  output logic [low_power_background_mode_pkg::DATA_W-1:0]          data_out,
  output logic [low_power_background_mode_pkg::TRIM_W-1:0]          core_offset_trim_out
);
  low_power_background_mode_pkg::lp_state_t state_q;
  logic [1:0]  pin_sync_q;
  logic        trig_q;
  logic [15:0] step_cnt_q;
  localparam int DLY_W_L = low_power_background_mode_pkg::DLY_W;
  logic [DLY_W_L-1:0] dly_cnt_q;
  logic [15:0] cal_cnt_q;
  logic        released_lo_q;
  logic        fg_busy_q;
  logic [15:0] fg_cnt_q;
  logic [2:0]  fg_core_q;
  logic        bg_os_tick_q;
  logic        seq_on;
  logic        step;
  logic        os_wr;
  logic [2:0]  os_idx;
  logic [low_power_background_mode_pkg::TRIM_W-1:0] os_val;
  logic        fg_os_on;

  // ----------------------------------------
  // Trigger pin synchroniser and selection
  // ----------------------------------------
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      pin_sync_q <= 2'h3; // Idle-high level, so release of reset shows no false low trigger
    else
      pin_sync_q <= {pin_sync_q[0], cal_trigger_pin_in};
  end

  // Registered trigger from the chosen source
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      trig_q <= 1'b1;
    else
      trig_q <= cfg_in.trig_src_pin ? pin_sync_q[1] : software_cal_trigger_in;
  end

  assign seq_on = cfg_in.bg_cal_en && cfg_in.lowpwr_bg_enable;

  // ----------------------------------------
  // Delay step divider
  // ----------------------------------------
  // One-cycle enable per delay step keeps every counter on the single clock
  always_ff @(posedge clock_in)
  begin
    if (rst_in || step)
      step_cnt_q <= 16'h0000;
    else
      step_cnt_q <= step_cnt_q + 16'h0001;
  end
  assign step = (int'(step_cnt_q) >= STEP_CYCLES - 1);

  // ----------------------------------------
  // Background sleep, wake, calibrate, swap
  // ----------------------------------------
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      state_q   <= low_power_background_mode_pkg::ST_IDLE;
      dly_cnt_q <= '0;
      cal_cnt_q <= 16'h0000;
    end
    else if (!seq_on || fg_busy_q)
      state_q <= low_power_background_mode_pkg::ST_IDLE;
    else
    begin
      case (state_q)
        low_power_background_mode_pkg::ST_IDLE:
        begin
          dly_cnt_q <= '0;
          state_q   <= low_power_background_mode_pkg::ST_SLEEP;
        end
        low_power_background_mode_pkg::ST_SLEEP:
        begin
          if (cfg_in.trig_mode)
          begin
            if (!trig_q)
            begin
              dly_cnt_q <= '0;
              state_q   <= low_power_background_mode_pkg::ST_WAKE;
            end
          end
          else if (dly_cnt_q >= cfg_in.sleep_dly)
          begin
            dly_cnt_q <= '0;
            state_q   <= low_power_background_mode_pkg::ST_WAKE;
          end
          else if (step)
            dly_cnt_q <= dly_cnt_q + DLY_W_L'(1);
        end
        low_power_background_mode_pkg::ST_WAKE:
        begin
          if (dly_cnt_q >= cfg_in.wake_dly)
          begin
            cal_cnt_q <= 16'h0000;
            state_q   <= low_power_background_mode_pkg::ST_CAL;
          end
          else if (step)
            dly_cnt_q <= dly_cnt_q + DLY_W_L'(1);
        end
        low_power_background_mode_pkg::ST_CAL:
        begin
          if (int'(cal_cnt_q) >= CAL_CYCLES - 1)
            state_q <= cfg_in.trig_mode ? low_power_background_mode_pkg::ST_HOLD : low_power_background_mode_pkg::ST_SWAP;
          else
            cal_cnt_q <= cal_cnt_q + 16'h0001;
        end
        low_power_background_mode_pkg::ST_HOLD:
        begin
          if (trig_q || !cfg_in.trig_mode)
            state_q <= low_power_background_mode_pkg::ST_SWAP;
        end
        low_power_background_mode_pkg::ST_SWAP:
        begin
          dly_cnt_q <= '0;
          state_q   <= low_power_background_mode_pkg::ST_SLEEP;
        end
        default:
          state_q <= low_power_background_mode_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Core rotation: swaps alternate cores 0 and 1; quad variant pairs spare 2 with core 0, spare 3 with core 1
  // ----------------------------------------
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      released_lo_q <= 1'b0;
    else if (state_q == low_power_background_mode_pkg::ST_SWAP)
      released_lo_q <= !released_lo_q;
  end

  // Status outputs straight from flip-flops
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      stat_out           <= '0;
      cal_status_pin_out <= 1'b0;
    end
    else
    begin
      stat_out.spare_pwr    <= (state_q == low_power_background_mode_pkg::ST_WAKE) || (state_q == low_power_background_mode_pkg::ST_CAL)
                               || (state_q == low_power_background_mode_pkg::ST_HOLD) || (!cfg_in.lowpwr_bg_enable && cfg_in.bg_cal_en);
      stat_out.cal_busy     <= (state_q == low_power_background_mode_pkg::ST_CAL) || fg_busy_q;
      stat_out.cal_done     <= (state_q == low_power_background_mode_pkg::ST_HOLD);
      // Quad variant alternates spares; others always use spare 2
      stat_out.spare_core   <= (cfg_in.variant == 2'h2 && released_lo_q) ? low_power_background_mode_pkg::CORE_SPARE_HI
                                                                         : low_power_background_mode_pkg::CORE_SPARE_LO;
      if (state_q == low_power_background_mode_pkg::ST_SWAP)
        stat_out.swapped_core <= released_lo_q ? 3'h1 : 3'h0;
      cal_status_pin_out    <= cfg_in.status_sel ? (state_q == low_power_background_mode_pkg::ST_HOLD)
                                                 : (state_q == low_power_background_mode_pkg::ST_CAL || fg_busy_q);
    end
  end

  // ----------------------------------------
  // Foreground calibration pass
  // ----------------------------------------
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      fg_busy_q                <= 1'b0;
      fg_cnt_q                 <= 16'h0000;
      foreground_done_flag_out <= 1'b0;
    end
    else if (fg_start_in && !fg_busy_q)
    begin
      fg_busy_q                <= 1'b1;
      fg_cnt_q                 <= 16'h0000;
      foreground_done_flag_out <= 1'b0;
    end
    else if (fg_busy_q)
    begin
      if (int'(fg_cnt_q) >= FG_CAL_CYCLES - 1)
      begin
        fg_busy_q                <= 1'b0;
        foreground_done_flag_out <= 1'b1;
      end
      else
        fg_cnt_q <= fg_cnt_q + 16'h0001;
    end
  end

  // Mid-scale output while the foreground pass runs
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      data_out <= low_power_background_mode_pkg::MID_CODE;
    else
      data_out <= fg_busy_q ? low_power_background_mode_pkg::MID_CODE : adc_data_in;
  end

  // ----------------------------------------
  // Offset calibration writes into the per-core offset trims
  // ----------------------------------------
  // Foreground offset: one write per core, all six when background is also on
  assign fg_os_on = fg_busy_q && cfg_in.fg_os_en;
  always_ff @(posedge clock_in)
  begin
    if (rst_in || !fg_busy_q)
      fg_core_q <= 3'h0;
    else if (fg_os_on && (int'(fg_core_q) < low_power_background_mode_pkg::NUM_CORES))
      fg_core_q <= fg_core_q + 3'h1;
  end

  // Background offset update once, in the cycle after each swap state
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      bg_os_tick_q <= 1'b0;
    else
      bg_os_tick_q <= cfg_in.bg_os_en && (state_q == low_power_background_mode_pkg::ST_SWAP);
  end

  // Foreground pass covers all cores only if background is on, else main cores 0 1 4 5
  always_comb
  begin
    os_wr  = 1'b0;
    os_idx = 3'h0;
    os_val = '0;
    if (fg_os_on && (int'(fg_core_q) < low_power_background_mode_pkg::NUM_CORES)
        && (cfg_in.bg_cal_en || (fg_core_q != 3'h2 && fg_core_q != 3'h3)))
    begin
      os_wr  = 1'b1;
      os_idx = fg_core_q;
      // Spare reference: main cores track the spare core's measured offset
      os_val = cfg_in.spare_ref ? adc_data_in : (low_power_background_mode_pkg::MID_CODE - adc_data_in);
    end
    else if (bg_os_tick_q)
    begin
      os_wr  = 1'b1;
      os_idx = stat_out.swapped_core;
      os_val = cfg_in.spare_ref ? adc_data_in : (low_power_background_mode_pkg::MID_CODE - adc_data_in);
    end
    else if (trim_wr_in && !os_cal_active_out)
    begin
      // User writes are ignored while offset calibration owns the trims
      os_wr  = 1'b1;
      os_idx = trim_idx_in;
      os_val = trim_data_in;
    end
  end

  // Offset calibration in use flag, visible to the controller
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      os_cal_active_out <= 1'b0;
    else
      os_cal_active_out <= cfg_in.bg_os_en || fg_os_on;
  end

  // ----------------------------------------
  // Trim storage; gain trims live elsewhere and calibration never touches them
  // ----------------------------------------
  trim_store #(
    .CORES (low_power_background_mode_pkg::NUM_CORES),
    .W     (low_power_background_mode_pkg::TRIM_W)
  ) u_offset_trims (
    .clock_in    (clock_in),
    .rst_in      (rst_in),
    .wr_en_in    (os_wr),
    .wr_idx_in   (os_idx),
    .wr_data_in  (os_val),
    .rd_idx_in   (trim_rd_idx_in),
    .rd_data_out (core_offset_trim_out)
  );

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_idle_when_off;
    @(posedge clock_in) disable iff (rst_in)
    !seq_on |=> state_q == low_power_background_mode_pkg::ST_IDLE;
  endproperty
  a_idle_when_off: assert property (p_idle_when_off) else $error("sequencer not idle when disabled");

  property p_hold_needs_trig;
    @(posedge clock_in) disable iff (rst_in)
    (state_q == low_power_background_mode_pkg::ST_HOLD && !trig_q && seq_on && !fg_busy_q && cfg_in.trig_mode)
      |=> state_q == low_power_background_mode_pkg::ST_HOLD;
  endproperty
  a_hold_needs_trig: assert property (p_hold_needs_trig) else $error("swap without trigger high");

  property p_sleep_while_trig;
    @(posedge clock_in) disable iff (rst_in)
    (state_q == low_power_background_mode_pkg::ST_SLEEP && trig_q && cfg_in.trig_mode) |=> state_q != low_power_background_mode_pkg::ST_WAKE;
  endproperty
  a_sleep_while_trig: assert property (p_sleep_while_trig) else $error("spare woke with trigger high");

  property p_auto_swap;
    @(posedge clock_in) disable iff (rst_in)
    (state_q == low_power_background_mode_pkg::ST_CAL && !cfg_in.trig_mode && seq_on && !fg_busy_q
      && int'(cal_cnt_q) >= CAL_CYCLES - 1) |=> state_q == low_power_background_mode_pkg::ST_SWAP;
  endproperty
  a_auto_swap: assert property (p_auto_swap) else $error("auto mode did not swap");

  property p_mid_code;
    @(posedge clock_in) disable iff (rst_in)
    fg_busy_q |=> data_out == low_power_background_mode_pkg::MID_CODE;
  endproperty
  a_mid_code: assert property (p_mid_code) else $error("output not mid-scale in foreground");

  property p_status_pin;
    @(posedge clock_in) disable iff (rst_in)
    (cfg_in.status_sel && state_q == low_power_background_mode_pkg::ST_HOLD) |=> cal_status_pin_out;
  endproperty
  a_status_pin: assert property (p_status_pin) else $error("status pin missed finished");

  property p_no_user_trim;
    @(posedge clock_in) disable iff (rst_in)
    (os_cal_active_out && trim_wr_in && !fg_os_on && !bg_os_tick_q) |-> !os_wr;
  endproperty
  a_no_user_trim: assert property (p_no_user_trim) else $error("user trim write during offset cal");

  property p_foreground_done_flag;
    @(posedge clock_in) disable iff (rst_in)
    $fell(fg_busy_q) |-> foreground_done_flag_out;
  endproperty
  a_foreground_done_flag: assert property (p_foreground_done_flag) else $error("foreground done not set");

  c_auto_cycle: cover property (@(posedge clock_in) disable iff (rst_in)
    state_q == low_power_background_mode_pkg::ST_CAL ##1 state_q == low_power_background_mode_pkg::ST_SWAP);
  c_hold_wait: cover property (@(posedge clock_in) disable iff (rst_in)
    state_q == low_power_background_mode_pkg::ST_HOLD [*3] ##1 state_q == low_power_background_mode_pkg::ST_SWAP);
  c_fg_pass: cover property (@(posedge clock_in) disable iff (rst_in) $rose(foreground_done_flag_out));
endmodule

/* File: src/trim_store.sv */
// Per-core offset trim storage with registered read port
`timescale 1ns/1ps
module trim_store #(
  parameter int CORES = 6,
  parameter int W     = 12
) (
  input  wire logic         clock_in,
  input  wire logic         rst_in,
  input  wire logic         wr_en_in,
  input  wire logic [2:0]   wr_idx_in,
  input  wire logic [W-1:0] wr_data_in,
  input  wire logic [2:0]   rd_idx_in,
  output logic      [W-1:0] rd_data_out
);
  logic [W-1:0] mem_q [CORES];

  // -----------------------------
  // Storage, one word per core
  // -----------------------------
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      for (int i = 0; i < CORES; i++)
        mem_q[i] <= '0;
    end
    else if (wr_en_in && (int'(wr_idx_in) < CORES))
      mem_q[wr_idx_in] <= wr_data_in;
  end

  // Read data registered so the caller sees one cycle of latency
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      rd_data_out <= '0;
    else if (int'(rd_idx_in) < CORES)
      rd_data_out <= mem_q[rd_idx_in];
    else
      rd_data_out <= '0;
  end
endmodule
